// *** core/dmp_defs.svh ***
`ifndef DMP_DEFS_SVH
`define DMP_DEFS_SVH

// Control register block base, matched against address bits 15:8
`define DMP_CSIOP_BASE 8'h00

// Device control register offsets, low address byte
`define DMP_OFF_PAGE 8'h00
`define DMP_OFF_B_OUT 8'h01
`define DMP_OFF_B_IN 8'h02
`define DMP_OFF_B_DIR 8'h03
`define DMP_OFF_B_OD 8'h04
`define DMP_OFF_B_MC 8'h05
`define DMP_OFF_C_OUT 8'h08
`define DMP_OFF_C_IN 8'h09
`define DMP_OFF_C_DIR 8'h0a
`define DMP_OFF_C_OD 8'h0b
`define DMP_OFF_C_MC 8'h0c
`define DMP_OFF_C_SPEC 8'h0d
`define DMP_OFF_IRQ_ST 8'h10
`define DMP_OFF_IRQ_MASK 8'h11

// Reset value of every byte register, idle level of the data bus
`define DMP_RST_BYTE 8'h00
`define DMP_BUS_IDLE 8'hff
`define DMP_ZERO_ADDR 16'h0000
// Only pins 0..3 of the first port support open drain
`define DMP_B_OD_MASK 8'h0f

// Special function enable bits of the second port
`define DMP_SPEC_JTAG 0
`define DMP_SPEC_ENH 1
`define DMP_SPEC_RDY 2

// Second port pin positions
`define DMP_PC_TMS 0
`define DMP_PC_TCK 1
`define DMP_PC_STAT 3
`define DMP_PC_ERR 4
`define DMP_PC_TDI 5
`define DMP_PC_TDO 6

// Interrupt event bits
`define DMP_EV_DONE 0
`define DMP_EV_ERR 1

// Synchronised control strobe positions
`define DMP_CTL_WR 0
`define DMP_CTL_RD 1
`define DMP_CTL_BMS 2
`define DMP_CTL_IO_SPACE_SELECT 3
`define DMP_CTL_RST 4
`define DMP_CTL_IDLE 5'h1f

// Host command register offsets
`define DMP_H_ADDR_LO 8'h00
`define DMP_H_ADDR_HI 8'h01
`define DMP_H_WDATA 8'h02
`define DMP_H_CTRL 8'h03
`define DMP_H_STAT 8'h04
`define DMP_H_RDATA 8'h05
`define DMP_H_IRQ_ST 8'h06
`define DMP_H_IRQ_MASK 8'h07
`define DMP_CTRL_WR 0
`define DMP_CTRL_RD 1
`define DMP_CTRL_BOOT 2

// Host bus timing
`define DMP_CLK_MHZ 200
`define DMP_SETUP_NS 10
`define DMP_STROBE_NS 40
`define DMP_HOLD_NS 20
`define DMP_RST_HOLD_NS 1000
`define DMP_CNT_ZERO 8'h00
`define DMP_CNT_ONE 8'h01

`endif

// *** core/dmp_pkg.sv ***
package dmp_pkg;
	typedef logic [7:0] dmp_byte_type;
	typedef logic [15:0] dmp_addr_type;
	// Host bus cycle phases
	typedef enum logic [3:0] {
		st_idle = 4'b0001,
		st_setup = 4'b0010,
		st_strobe = 4'b0100,
		st_hold = 4'b1000
	} dmp_state_type;
endpackage : dmp_pkg

// *** core/dmp_if.sv ***
`include "dmp_defs.svh"
interface dmp_if;
	import dmp_pkg::*;
	dmp_addr_type host_address_inputs;
	logic host_write_strobe_n;
	logic host_read_strobe_n;
	logic byte_memory_select_n;
	logic io_space_select_n;
	logic sys_reset_n;
	dmp_byte_type host_data_out;
	logic host_data_oe;
	dmp_byte_type dev_data_out;
	logic dev_data_oe;
	dmp_byte_type host_data_byte;
	// Resolved bus level; pulled high when nobody drives
	assign host_data_byte = dev_data_oe ? dev_data_out :
		(host_data_oe ? host_data_out : `DMP_BUS_IDLE);
	modport device(
		input host_address_inputs, host_write_strobe_n, host_read_strobe_n,
		input byte_memory_select_n, io_space_select_n, sys_reset_n,
		input host_data_byte,
		output dev_data_out, dev_data_oe
	);
	modport host(
		output host_address_inputs, host_write_strobe_n, host_read_strobe_n,
		output byte_memory_select_n, io_space_select_n, sys_reset_n,
		output host_data_out, host_data_oe,
		input host_data_byte
	);
endinterface : dmp_if

// *** core/dmp_device.sv ***
//
// Contract
// [R1] System reset clears ports, page, configuration
// [R2] System holds reset low during power-up
// [R3] Sixteen address pins are inputs only
// [R4] Data byte carries host data bits 8-15
// [R5] Read strobe low performs read access
// [R6] Byte memory select qualifies boot space
// [R7] First port pins: software, macrocell, logic input
// [R8] First port pins 0-3 push-pull or open-drain
// [R9] Second port pins: software, macrocell, logic input
// [R10] Second port pins push-pull or open-drain each
// [R11] Second port 0,1,5,6 carry test port
// [R12] Second port 3,4 carry status, error
// [R13] Second port 3 may show ready/busy
// [R14] Route io select to second port pin 2; not done here, io select only enters the control register decode
// [R15] Route address bit 16 to third port; not done here, the address has only bits 15:0 and there is no third port
// [R16] Write strobe low performs write access
// [R17] Control registers reached bytewise under io select
// [R18] Software pin drives output, reads pin level
// [R19] Open-drain pin drives only low
`include "dmp_defs.svh"
module dmp_device (
	input wire logic clk_in,
	input wire logic rst_in,
	dmp_if.device bus,
	input wire dmp_pkg::dmp_byte_type first_general_port_in,
	output logic [7:0] first_general_port_out,
	output logic [7:0] first_general_port_oe_out,
	input wire dmp_pkg::dmp_byte_type second_general_port_in,
	output logic [7:0] second_general_port_out,
	output logic [7:0] second_general_port_oe_out,
	input wire dmp_pkg::dmp_byte_type logic_macrocell_outputs_low_in,
	input wire dmp_pkg::dmp_byte_type logic_macrocell_outputs_high_in,
	output dmp_pkg::dmp_byte_type pld_first_inputs_out,
	output dmp_pkg::dmp_byte_type pld_second_inputs_out,
	output dmp_pkg::dmp_byte_type page_out,
	output logic tms_out,
	output logic tck_out,
	output logic tdi_out,
	input wire logic tdo_in,
	input wire logic programming_status_in,
	input wire logic programming_error_in,
	input wire logic ready_busy_in,
	input wire dmp_pkg::dmp_byte_type boot_data_in,
	output dmp_pkg::dmp_addr_type boot_addr_out,
	output logic boot_read_out,
	output logic irq_out
);
	import dmp_pkg::*;

	dmp_addr_type addr_s1, addr_s2;
	logic [4:0] ctl_s1, ctl_s2;
	dmp_byte_type data_s1, data_s2;
	dmp_byte_type pb_s1, pb_s2, pc_s1, pc_s2;
	logic wr_prev_r;
	logic cfg_rst, csiop_hit, wr_pulse, rd_active, boot_active;
	dmp_byte_type reg_off, rd_mux;
	dmp_byte_type page_r, b_out_r, b_dir_r, b_od_r, b_mc_r;
	dmp_byte_type c_out_r, c_dir_r, c_od_r, c_mc_r, c_spec_r;
	dmp_byte_type irq_st_r, irq_mask_r, irq_st_nxt, irq_ev;
	logic rdy_prev_r, err_prev_r;
	logic [7:0] pb_raw_out, pb_raw_oe, pc_raw_out, pc_raw_oe;
	logic [7:0] pc_fin_out, pc_fin_oe;
	dmp_byte_type dev_data_r;
	logic dev_oe_r;

	// Pin drive decode: returns {oe, out}
	function automatic logic [1:0] pin_drive(input logic mc_sel,
			input logic mc_val, input logic dir, input logic sw_val,
			input logic od);
		logic drive;
		logic val;
		drive = mc_sel | dir;
		val = mc_sel ? mc_val : sw_val;
		if (od) begin
			pin_drive = {drive & ~val, 1'b0}; // [R19]
		end else begin
			pin_drive = {drive, val};
		end
	endfunction : pin_drive

	// Two-stage synchronisers for the host bus and both port inputs
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			addr_s1 <= `DMP_ZERO_ADDR;
			addr_s2 <= `DMP_ZERO_ADDR;
			ctl_s1 <= `DMP_CTL_IDLE;
			ctl_s2 <= `DMP_CTL_IDLE;
			data_s1 <= `DMP_RST_BYTE;
			data_s2 <= `DMP_RST_BYTE;
			pb_s1 <= `DMP_RST_BYTE;
			pb_s2 <= `DMP_RST_BYTE;
			pc_s1 <= `DMP_RST_BYTE;
			pc_s2 <= `DMP_RST_BYTE;
		end else begin
			addr_s1 <= bus.host_address_inputs; // [R3]
			addr_s2 <= addr_s1;
			ctl_s1 <= {bus.sys_reset_n, bus.io_space_select_n,
				bus.byte_memory_select_n, bus.host_read_strobe_n,
				bus.host_write_strobe_n};
			ctl_s2 <= ctl_s1;
			data_s1 <= bus.host_data_byte;
			data_s2 <= data_s1;
			pb_s1 <= first_general_port_in;
			pb_s2 <= pb_s1;
			pc_s1 <= second_general_port_in;
			pc_s2 <= pc_s1;
		end
	end

	// Decode; the system reset pin is only trusted once synchronised
	assign cfg_rst = rst_in | ~ctl_s2[`DMP_CTL_RST]; // [R1] [R2]
	assign csiop_hit = ~ctl_s2[`DMP_CTL_IO_SPACE_SELECT] &
		(addr_s2[15:8] == `DMP_CSIOP_BASE); // [R17]
	assign reg_off = addr_s2[7:0];
	assign wr_pulse = wr_prev_r & ~ctl_s2[`DMP_CTL_WR] & csiop_hit; // [R16]
	assign rd_active = ~ctl_s2[`DMP_CTL_RD] & csiop_hit; // [R5]
	assign boot_active = ~ctl_s2[`DMP_CTL_RD] &
		~ctl_s2[`DMP_CTL_BMS]; // [R6]

	// Falling-edge detect on the write strobe, one write per strobe
	always_ff @(posedge clk_in) begin
		if (cfg_rst) begin
			wr_prev_r <= 1'b1;
		end else begin
			wr_prev_r <= ctl_s2[`DMP_CTL_WR];
		end
	end

	// Configuration registers, one byte per access
	always_ff @(posedge clk_in) begin
		if (cfg_rst) begin // [R1]
			page_r <= `DMP_RST_BYTE;
			b_out_r <= `DMP_RST_BYTE;
			b_dir_r <= `DMP_RST_BYTE;
			b_od_r <= `DMP_RST_BYTE;
			b_mc_r <= `DMP_RST_BYTE;
			c_out_r <= `DMP_RST_BYTE;
			c_dir_r <= `DMP_RST_BYTE;
			c_od_r <= `DMP_RST_BYTE;
			c_mc_r <= `DMP_RST_BYTE;
			c_spec_r <= `DMP_RST_BYTE;
			irq_mask_r <= `DMP_RST_BYTE;
		end else if (wr_pulse) begin
			unique case (reg_off)
				`DMP_OFF_PAGE: page_r <= data_s2; // [R4]
				`DMP_OFF_B_OUT: b_out_r <= data_s2; // [R18]
				`DMP_OFF_B_DIR: b_dir_r <= data_s2; // [R7]
				`DMP_OFF_B_OD: b_od_r <= data_s2 & `DMP_B_OD_MASK; // [R8]
				`DMP_OFF_B_MC: b_mc_r <= data_s2; // [R7]
				`DMP_OFF_C_OUT: c_out_r <= data_s2; // [R18]
				`DMP_OFF_C_DIR: c_dir_r <= data_s2; // [R9]
				`DMP_OFF_C_OD: c_od_r <= data_s2; // [R10]
				`DMP_OFF_C_MC: c_mc_r <= data_s2; // [R9]
				`DMP_OFF_C_SPEC: c_spec_r <= data_s2;
				`DMP_OFF_IRQ_MASK: irq_mask_r <= data_s2;
				default: ;
			endcase
		end
	end

	// Events: flash operation finished, programming error raised
	always_comb begin
		irq_ev = `DMP_RST_BYTE;
		irq_ev[`DMP_EV_DONE] = ready_busy_in & ~rdy_prev_r; // [R13]
		irq_ev[`DMP_EV_ERR] = programming_error_in & ~err_prev_r;
		irq_st_nxt = irq_st_r;
		if (wr_pulse && reg_off == `DMP_OFF_IRQ_ST) begin
			irq_st_nxt = irq_st_r & ~data_s2;
		end
		// Set beats clear so no event is lost
		irq_st_nxt = irq_st_nxt | irq_ev;
	end

	// Sticky status and the level interrupt
	always_ff @(posedge clk_in) begin
		if (cfg_rst) begin
			irq_st_r <= `DMP_RST_BYTE;
			rdy_prev_r <= 1'b1;
			err_prev_r <= 1'b0;
			irq_out <= 1'b0;
		end else begin
			irq_st_r <= irq_st_nxt;
			rdy_prev_r <= ready_busy_in;
			err_prev_r <= programming_error_in;
			irq_out <= |(irq_st_nxt & irq_mask_r);
		end
	end

	// Per-pin function select, shared decode for both ports
	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_pin
			assign {pb_raw_oe[i], pb_raw_out[i]} = pin_drive(b_mc_r[i],
				logic_macrocell_outputs_low_in[i], b_dir_r[i], b_out_r[i],
				b_od_r[i]); // [R7] [R8]
			assign {pc_raw_oe[i], pc_raw_out[i]} = pin_drive(c_mc_r[i],
				logic_macrocell_outputs_high_in[i], c_dir_r[i], c_out_r[i],
				c_od_r[i]); // [R9] [R10]
		end
	endgenerate

	// Special functions override the general use of the second port
	always_comb begin
		pc_fin_out = pc_raw_out;
		pc_fin_oe = pc_raw_oe;
		if (c_spec_r[`DMP_SPEC_JTAG]) begin // [R11]
			pc_fin_oe[`DMP_PC_TMS] = 1'b0;
			pc_fin_oe[`DMP_PC_TCK] = 1'b0;
			pc_fin_oe[`DMP_PC_TDI] = 1'b0;
			pc_fin_oe[`DMP_PC_TDO] = 1'b1;
			pc_fin_out[`DMP_PC_TDO] = tdo_in;
		end
		if (c_spec_r[`DMP_SPEC_ENH]) begin // [R12]
			pc_fin_oe[`DMP_PC_STAT] = 1'b1;
			pc_fin_out[`DMP_PC_STAT] = programming_status_in;
			pc_fin_oe[`DMP_PC_ERR] = 1'b1;
			pc_fin_out[`DMP_PC_ERR] = programming_error_in;
		end else if (c_spec_r[`DMP_SPEC_RDY]) begin // [R13]
			pc_fin_oe[`DMP_PC_STAT] = 1'b1;
			pc_fin_out[`DMP_PC_STAT] = ready_busy_in;
		end
	end

	// Registered pin drivers and logic inputs
	always_ff @(posedge clk_in) begin
		if (cfg_rst) begin
			first_general_port_out <= `DMP_RST_BYTE;
			first_general_port_oe_out <= `DMP_RST_BYTE;
			second_general_port_out <= `DMP_RST_BYTE;
			second_general_port_oe_out <= `DMP_RST_BYTE;
			pld_first_inputs_out <= `DMP_RST_BYTE;
			pld_second_inputs_out <= `DMP_RST_BYTE;
			tms_out <= 1'b0;
			tck_out <= 1'b0;
			tdi_out <= 1'b0;
		end else begin
			first_general_port_out <= pb_raw_out;
			first_general_port_oe_out <= pb_raw_oe;
			second_general_port_out <= pc_fin_out;
			second_general_port_oe_out <= pc_fin_oe;
			pld_first_inputs_out <= pb_s2; // [R7]
			pld_second_inputs_out <= pc_s2; // [R9] [R14]
			tms_out <= c_spec_r[`DMP_SPEC_JTAG] & pc_s2[`DMP_PC_TMS]; // [R11]
			tck_out <= c_spec_r[`DMP_SPEC_JTAG] & pc_s2[`DMP_PC_TCK];
			tdi_out <= c_spec_r[`DMP_SPEC_JTAG] & pc_s2[`DMP_PC_TDI];
		end
	end

	// Read multiplexer; unmapped offsets read as zero
	always_comb begin
		unique case (reg_off)
			`DMP_OFF_PAGE: rd_mux = page_r;
			`DMP_OFF_B_OUT: rd_mux = b_out_r;
			`DMP_OFF_B_IN: rd_mux = pb_s2; // [R18]
			`DMP_OFF_B_DIR: rd_mux = b_dir_r;
			`DMP_OFF_B_OD: rd_mux = b_od_r;
			`DMP_OFF_B_MC: rd_mux = b_mc_r;
			`DMP_OFF_C_OUT: rd_mux = c_out_r;
			`DMP_OFF_C_IN: rd_mux = pc_s2; // [R18]
			`DMP_OFF_C_DIR: rd_mux = c_dir_r;
			`DMP_OFF_C_OD: rd_mux = c_od_r;
			`DMP_OFF_C_MC: rd_mux = c_mc_r;
			`DMP_OFF_C_SPEC: rd_mux = c_spec_r;
			`DMP_OFF_IRQ_ST: rd_mux = irq_st_r;
			`DMP_OFF_IRQ_MASK: rd_mux = irq_mask_r;
			default: rd_mux = `DMP_RST_BYTE;
		endcase
	end

	// Data bus drive; released within three cycles of the strobe rising
	always_ff @(posedge clk_in) begin
		if (cfg_rst) begin
			dev_data_r <= `DMP_RST_BYTE;
			dev_oe_r <= 1'b0;
			boot_read_out <= 1'b0;
			boot_addr_out <= `DMP_ZERO_ADDR;
		end else begin
			dev_oe_r <= rd_active | boot_active; // [R5] [R6]
			dev_data_r <= boot_active ? boot_data_in : rd_mux; // [R4]
			boot_read_out <= boot_active;
			boot_addr_out <= addr_s2;
		end
	end

	assign bus.dev_data_out = dev_data_r;
	assign bus.dev_data_oe = dev_oe_r;
	assign page_out = page_r;
endmodule : dmp_device

// *** core/dmp_host.sv ***
`include "dmp_defs.svh"
module dmp_host (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire dmp_pkg::dmp_byte_type reg_addr_in,
	input wire dmp_pkg::dmp_byte_type reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output dmp_pkg::dmp_byte_type reg_rdata_out,
	output logic irq_out,
	dmp_if.host bus
);
	import dmp_pkg::*;

	// Least times, rounded up to whole cycles
	localparam logic [7:0] SETUP_CYC =
		8'((`DMP_SETUP_NS * `DMP_CLK_MHZ + 999) / 1000);
	localparam logic [7:0] STROBE_CYC =
		8'((`DMP_STROBE_NS * `DMP_CLK_MHZ + 999) / 1000);
	localparam logic [7:0] HOLD_CYC =
		8'((`DMP_HOLD_NS * `DMP_CLK_MHZ + 999) / 1000);
	localparam logic [7:0] RST_CYC =
		8'((`DMP_RST_HOLD_NS * `DMP_CLK_MHZ + 999) / 1000);

	dmp_state_type state_r;
	logic [7:0] cnt_r, rst_cnt_r;
	dmp_addr_type addr_r;
	dmp_byte_type wdata_r, rdata_r, irq_st_r, irq_mask_r, irq_st_nxt;
	dmp_byte_type data_s1, data_s2;
	logic is_read_r, is_boot_r, done_ev, start_ok, cnt_last;
	logic wr_n_r, rd_n_r, bms_n_r, io_space_select_n_r, sysrst_n_r, oe_r;

	assign start_ok = reg_wr_in & (reg_addr_in == `DMP_H_CTRL) &
		(state_r == st_idle) & sysrst_n_r;
	assign done_ev = (state_r == st_hold) & cnt_last;

	// Power-up reset held low for a minimum time
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			rst_cnt_r <= `DMP_CNT_ZERO;
			sysrst_n_r <= 1'b0;
		end else if (rst_cnt_r != RST_CYC) begin
			rst_cnt_r <= rst_cnt_r + `DMP_CNT_ONE;
			sysrst_n_r <= 1'b0; // [R2]
		end else begin
			sysrst_n_r <= 1'b1;
		end
	end

	// Returned data crosses from the pins, two stages
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			data_s1 <= `DMP_RST_BYTE;
			data_s2 <= `DMP_RST_BYTE;
		end else begin
			data_s1 <= bus.host_data_byte;
			data_s2 <= data_s1;
		end
	end

	// Command registers
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			addr_r <= `DMP_ZERO_ADDR;
			wdata_r <= `DMP_RST_BYTE;
			irq_mask_r <= `DMP_RST_BYTE;
		end else if (reg_wr_in) begin
			unique case (reg_addr_in)
				`DMP_H_ADDR_LO: addr_r[7:0] <= reg_wdata_in;
				`DMP_H_ADDR_HI: addr_r[15:8] <= reg_wdata_in;
				`DMP_H_WDATA: wdata_r <= reg_wdata_in;
				`DMP_H_IRQ_MASK: irq_mask_r <= reg_wdata_in;
				default: ;
			endcase
		end
	end

	// Phase counter resets on each phase change
	assign cnt_last = (state_r == st_setup && cnt_r == SETUP_CYC -
		`DMP_CNT_ONE) || (state_r == st_strobe && cnt_r == STROBE_CYC -
		`DMP_CNT_ONE) || (state_r == st_hold && cnt_r == HOLD_CYC -
		`DMP_CNT_ONE);

	// Bus cycle sequencer; commands during a cycle are dropped
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_r <= st_idle;
			cnt_r <= `DMP_CNT_ZERO;
			is_read_r <= 1'b0;
			is_boot_r <= 1'b0;
			rdata_r <= `DMP_RST_BYTE;
			wr_n_r <= 1'b1;
			rd_n_r <= 1'b1;
			bms_n_r <= 1'b1;
			io_space_select_n_r <= 1'b1;
			oe_r <= 1'b0;
		end else begin
			cnt_r <= cnt_last ? `DMP_CNT_ZERO : cnt_r + `DMP_CNT_ONE;
			unique case (state_r)
				st_idle: begin
					cnt_r <= `DMP_CNT_ZERO;
					if (start_ok && (reg_wdata_in[`DMP_CTRL_WR] ||
							reg_wdata_in[`DMP_CTRL_RD])) begin
						state_r <= st_setup;
						is_read_r <= ~reg_wdata_in[`DMP_CTRL_WR];
						is_boot_r <= reg_wdata_in[`DMP_CTRL_BOOT];
						bms_n_r <= ~reg_wdata_in[`DMP_CTRL_BOOT]; // [R6]
						io_space_select_n_r <= reg_wdata_in[`DMP_CTRL_BOOT]; // [R17] [R14]
						oe_r <= reg_wdata_in[`DMP_CTRL_WR]; // [R4]
					end
				end
				st_setup: begin
					if (cnt_last) begin
						state_r <= st_strobe;
						rd_n_r <= ~is_read_r; // [R5]
						wr_n_r <= is_read_r | is_boot_r; // [R16]
					end
				end
				st_strobe: begin
					if (cnt_last) begin
						state_r <= st_hold;
						if (is_read_r) begin
							rdata_r <= data_s2;
						end
						rd_n_r <= 1'b1;
						wr_n_r <= 1'b1;
					end
				end
				st_hold: begin
					if (cnt_last) begin
						state_r <= st_idle;
						bms_n_r <= 1'b1;
						io_space_select_n_r <= 1'b1;
						oe_r <= 1'b0;
					end
				end
			endcase
		end
	end

	// Sticky done flag, write one to clear, set wins
	always_comb begin
		irq_st_nxt = irq_st_r;
		if (reg_wr_in && reg_addr_in == `DMP_H_IRQ_ST) begin
			irq_st_nxt = irq_st_r & ~reg_wdata_in;
		end
		irq_st_nxt[`DMP_EV_DONE] = irq_st_nxt[`DMP_EV_DONE] | done_ev;
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			irq_st_r <= `DMP_RST_BYTE;
			irq_out <= 1'b0;
		end else begin
			irq_st_r <= irq_st_nxt;
			irq_out <= |(irq_st_nxt & irq_mask_r);
		end
	end

	// Register read data, one cycle after the strobe
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			reg_rdata_out <= `DMP_RST_BYTE;
		end else if (reg_rd_in) begin
			unique case (reg_addr_in)
				`DMP_H_ADDR_LO: reg_rdata_out <= addr_r[7:0];
				`DMP_H_ADDR_HI: reg_rdata_out <= addr_r[15:8];
				`DMP_H_WDATA: reg_rdata_out <= wdata_r;
				`DMP_H_STAT: reg_rdata_out <= {6'h00, sysrst_n_r,
					state_r != st_idle};
				`DMP_H_RDATA: reg_rdata_out <= rdata_r;
				`DMP_H_IRQ_ST: reg_rdata_out <= irq_st_r;
				`DMP_H_IRQ_MASK: reg_rdata_out <= irq_mask_r;
				default: reg_rdata_out <= `DMP_RST_BYTE;
			endcase
		end else begin
			reg_rdata_out <= `DMP_RST_BYTE;
		end
	end

	// Pin drivers all come from flops
	assign bus.host_address_inputs = addr_r; // [R3]
	assign bus.host_data_out = wdata_r;
	assign bus.host_data_oe = oe_r;
	assign bus.host_write_strobe_n = wr_n_r;
	assign bus.host_read_strobe_n = rd_n_r;
	assign bus.byte_memory_select_n = bms_n_r;
	assign bus.io_space_select_n = io_space_select_n_r;
	assign bus.sys_reset_n = sysrst_n_r;
endmodule : dmp_host

// *** verification/dmp_checker.sv ***
module dmp_checker (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire dmp_pkg::dmp_addr_type host_address_inputs,
	input wire logic host_write_strobe_n,
	input wire logic host_read_strobe_n,
	input wire logic byte_memory_select_n,
	input wire logic io_space_select_n,
	input wire logic sys_reset_n,
	input wire dmp_pkg::dmp_byte_type host_data_out,
	input wire logic host_data_oe,
	input wire logic dev_data_oe
);
	import dmp_pkg::*;
	// One clock for all link checks, quiet during reset
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	property p_rst_hold;
		$fell(rst_in) |-> !sys_reset_n [*8];
	endproperty
	a_rst_hold: assert property (p_rst_hold)
		else $error("system reset released too early");
	property p_rst_quiet;
		!sys_reset_n |-> host_read_strobe_n && host_write_strobe_n &&
			!dev_data_oe;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet)
		else $error("bus active while system reset low");
	property p_rd_answer;
		$fell(host_read_strobe_n) |-> ##[2:4] dev_data_oe;
	endproperty
	a_rd_answer: assert property (p_rd_answer)
		else $error("device did not answer read strobe");
	property p_rd_release;
		$rose(host_read_strobe_n) |-> ##[2:4] !dev_data_oe;
	endproperty
	a_rd_release: assert property (p_rd_release)
		else $error("device kept driving after read");
	// Strobe low lasts at least eight cycles, so five high means idle
	property p_rd_idle;
		host_read_strobe_n && $past(host_read_strobe_n, 5) |-> !dev_data_oe;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("device drove bus without read");
	property p_no_fight;
		!(dev_data_oe && host_data_oe);
	endproperty
	a_no_fight: assert property (p_no_fight)
		else $error("both ends drive the data byte");
	property p_strobe_excl;
		!(!host_write_strobe_n && !host_read_strobe_n);
	endproperty
	a_strobe_excl: assert property (p_strobe_excl)
		else $error("read and write strobe low together");
	property p_wr_select;
		!host_write_strobe_n |-> !io_space_select_n && byte_memory_select_n;
	endproperty
	a_wr_select: assert property (p_wr_select)
		else $error("write strobe outside io space");
	property p_rd_select;
		!host_read_strobe_n |-> (io_space_select_n != byte_memory_select_n);
	endproperty
	a_rd_select: assert property (p_rd_select)
		else $error("read strobe without exactly one select");
	property p_wr_len;
		$fell(host_write_strobe_n) |-> !host_write_strobe_n [*8] ##1
			host_write_strobe_n;
	endproperty
	a_wr_len: assert property (p_wr_len)
		else $error("write strobe length wrong");
	property p_wr_data;
		!host_write_strobe_n |-> host_data_oe && $stable(host_data_out) &&
			$stable(host_address_inputs);
	endproperty
	a_wr_data: assert property (p_wr_data)
		else $error("address or data moved under write strobe");
endmodule : dmp_checker

// *** verification/tb_dsp_memory_port_pin_functions.sv ***
`include "dmp_defs.svh"
`define CHK(a, e) begin \
	checks_done++; \
	if ((a) !== (e)) begin \
		num_errors++; \
		$display("MISMATCH %0t got %h exp %h", $time, (a), (e)); \
	end \
end
module tb_dsp_memory_port_pin_functions;
	timeunit 1ns;
	timeprecision 1ps;
	import dmp_pkg::*;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic tdo = 1'b0;
	logic stat = 1'b0;
	logic err = 1'b0;
	logic rdy = 1'b0;
	logic host_irq, dev_irq, tms, tck, tdi;
	dmp_byte_type reg_addr = 8'h00;
	dmp_byte_type reg_wdata = 8'h00;
	dmp_byte_type p1_in = 8'h00;
	dmp_byte_type p2_in = 8'h00;
	dmp_byte_type mc_lo = 8'h00;
	dmp_byte_type mc_hi = 8'h00;
	dmp_byte_type boot = 8'h00;
	dmp_byte_type reg_rdata, pld1, pld2, page, got;
	dmp_addr_type baddr;
	logic [7:0] p1_out, p1_oe, p2_out, p2_oe;
	int num_errors = 0;
	int checks_done = 0;
	dmp_if bus_if();
	dmp_host u_dmp_host (.clk_in(clk_in), .rst_in(rst_in),
		.reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
		.reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
		.reg_rdata_out(reg_rdata), .irq_out(host_irq), .bus(bus_if.host));
	dmp_device u_dmp_device (.clk_in(clk_in), .rst_in(rst_in),
		.bus(bus_if.device), .first_general_port_in(p1_in),
		.first_general_port_out(p1_out), .first_general_port_oe_out(p1_oe),
		.second_general_port_in(p2_in), .second_general_port_out(p2_out),
		.second_general_port_oe_out(p2_oe),
		.logic_macrocell_outputs_low_in(mc_lo),
		.logic_macrocell_outputs_high_in(mc_hi),
		.pld_first_inputs_out(pld1), .pld_second_inputs_out(pld2),
		.page_out(page), .tms_out(tms), .tck_out(tck), .tdi_out(tdi),
		.tdo_in(tdo), .programming_status_in(stat),
		.programming_error_in(err), .ready_busy_in(rdy),
		.boot_data_in(boot), .boot_addr_out(baddr), .boot_read_out(),
		.irq_out(dev_irq));
	dmp_checker u_dmp_checker (.clk_in(clk_in), .rst_in(rst_in),
		.host_address_inputs(bus_if.host_address_inputs),
		.host_write_strobe_n(bus_if.host_write_strobe_n),
		.host_read_strobe_n(bus_if.host_read_strobe_n),
		.byte_memory_select_n(bus_if.byte_memory_select_n),
		.io_space_select_n(bus_if.io_space_select_n),
		.sys_reset_n(bus_if.sys_reset_n),
		.host_data_out(bus_if.host_data_out),
		.host_data_oe(bus_if.host_data_oe), .dev_data_oe(bus_if.dev_data_oe));
	// 200 MHz clock
	initial begin
		forever #2.5 clk_in = ~clk_in;
	end
	// Register port strobes, one cycle each
	task automatic wr(input dmp_byte_type a, input dmp_byte_type d);
		@(posedge clk_in);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_in);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input dmp_byte_type a, output dmp_byte_type d);
		@(posedge clk_in);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_in);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd
	// Done flag cleared first, so every cycle raises a fresh one
	task automatic bus(input dmp_addr_type a, input dmp_byte_type d,
		input dmp_byte_type c);
		int n;
		wr(`DMP_H_IRQ_ST, 8'h01);
		wr(`DMP_H_ADDR_LO, a[7:0]);
		wr(`DMP_H_ADDR_HI, a[15:8]);
		wr(`DMP_H_WDATA, d);
		wr(`DMP_H_CTRL, c);
		n = 0;
		do begin
			rd(`DMP_H_STAT, got);
			n++;
		end while (got[0] !== 1'b0 && n < 60);
		`CHK(got[0], 1'b0)
	endtask : bus
	task automatic bw(input dmp_byte_type o, input dmp_byte_type d);
		bus({`DMP_CSIOP_BASE, o}, d, 8'h01);
	endtask : bw
	task automatic br(input dmp_addr_type a, input logic b);
		bus(a, 8'h00, b ? 8'h06 : 8'h02);
		rd(`DMP_H_RDATA, got);
	endtask : br
	// Reset, then wait for the host to release system reset
	task automatic t_reset;
		int n;
		@(posedge clk_in);
		rst_in <= 1'b1;
		repeat (16) @(posedge clk_in);
		rst_in <= 1'b0;
		n = 0;
		do begin
			rd(`DMP_H_STAT, got);
			n++;
		end while (got[1] !== 1'b1 && n < 300);
		`CHK(got[1], 1'b1)
		`CHK(page, 8'h00)
		`CHK({p1_oe, p2_oe}, 16'h0000)
		br({`DMP_CSIOP_BASE, `DMP_OFF_C_SPEC}, 1'b0);
		`CHK(got, 8'h00)
	endtask : t_reset
	task automatic t_page;
		bw(`DMP_OFF_PAGE, 8'ha5);
		`CHK(page, 8'ha5)
		br({`DMP_CSIOP_BASE, `DMP_OFF_PAGE}, 1'b0);
		`CHK(got, 8'ha5)
		bus(16'h0100, 8'h5a, 8'h01);
		`CHK(page, 8'ha5)
		br({`DMP_CSIOP_BASE, 8'h07}, 1'b0);
		`CHK(got, 8'h00)
		rd(8'h20, got);
		`CHK(got, 8'h00)
	endtask : t_page
	// Pins 0..3 open drain: value 1 releases, so oe low nibble is ~out
	task automatic t_port1;
		bw(`DMP_OFF_B_DIR, 8'hff);
		bw(`DMP_OFF_B_OUT, 8'h35);
		`CHK(p1_out, 8'h35)
		`CHK(p1_oe, 8'hff)
		bw(`DMP_OFF_B_OD, 8'hff);
		`CHK(p1_oe, 8'hfa)
		`CHK(p1_out, 8'h30)
		bw(`DMP_OFF_B_OD, 8'h00);
		@(posedge clk_in);
		mc_lo <= 8'hc3;
		bw(`DMP_OFF_B_MC, 8'hff);
		`CHK(p1_out, 8'hc3)
		bw(`DMP_OFF_B_MC, 8'h00);
		bw(`DMP_OFF_B_DIR, 8'h00);
		@(posedge clk_in);
		p1_in <= 8'h96;
		br({`DMP_CSIOP_BASE, `DMP_OFF_B_IN}, 1'b0);
		`CHK(got, 8'h96)
		`CHK(pld1, 8'h96)
		`CHK(p1_oe, 8'h00)
	endtask : t_port1
	task automatic t_port2;
		bw(`DMP_OFF_C_DIR, 8'hff);
		bw(`DMP_OFF_C_OUT, 8'h0f);
		`CHK(p2_out, 8'h0f)
		bw(`DMP_OFF_C_OD, 8'hff);
		`CHK(p2_oe, 8'hf0)
		`CHK(p2_out, 8'h00)
		bw(`DMP_OFF_C_OD, 8'h00);
		@(posedge clk_in);
		mc_hi <= 8'ha5;
		bw(`DMP_OFF_C_MC, 8'hf0);
		`CHK(p2_out, 8'haf)
		bw(`DMP_OFF_C_MC, 8'h00);
		bw(`DMP_OFF_C_DIR, 8'h00);
		@(posedge clk_in);
		p2_in <= 8'h23;
		br({`DMP_CSIOP_BASE, `DMP_OFF_C_IN}, 1'b0);
		`CHK(got, 8'h23)
		`CHK(pld2, 8'h23)
	endtask : t_port2
	// Pins 0, 1 and 5 are high from the previous scenario
	task automatic t_spec;
		@(posedge clk_in);
		tdo <= 1'b1;
		stat <= 1'b1;
		err <= 1'b1;
		bw(`DMP_OFF_C_SPEC, 8'h01);
		`CHK({tms, tck, tdi}, 3'h7)
		`CHK({p2_oe[6], p2_out[6]}, 2'h3)
		bw(`DMP_OFF_C_SPEC, 8'h02);
		`CHK(p2_oe[4:3], 2'h3)
		`CHK(p2_out[4:3], 2'h3)
		bw(`DMP_OFF_C_SPEC, 8'h04);
		`CHK({tms, tck, tdi}, 3'h0)
		`CHK(p2_out[3], 1'b0)
		@(posedge clk_in);
		rdy <= 1'b1;
		repeat (6) @(posedge clk_in);
		#1;
		`CHK(p2_out[3], 1'b1)
	endtask : t_spec
	// Ready and error edges of the previous scenario left status set
	task automatic t_irq;
		bw(`DMP_OFF_IRQ_MASK, 8'h01);
		`CHK(dev_irq, 1'b1)
		bw(`DMP_OFF_IRQ_ST, 8'h01);
		`CHK(dev_irq, 1'b0)
		bw(`DMP_OFF_IRQ_MASK, 8'h00);
		@(posedge clk_in);
		rdy <= 1'b0;
		@(posedge clk_in);
		rdy <= 1'b1;
		br({`DMP_CSIOP_BASE, `DMP_OFF_IRQ_ST}, 1'b0);
		`CHK(got, 8'h03)
		`CHK(dev_irq, 1'b0)
		wr(`DMP_H_IRQ_MASK, 8'h01);
		bw(`DMP_OFF_PAGE, 8'h11);
		`CHK(host_irq, 1'b1)
		wr(`DMP_H_IRQ_ST, 8'h01);
		repeat (2) @(posedge clk_in);
		`CHK(host_irq, 1'b0)
	endtask : t_irq
	task automatic t_boot;
		@(posedge clk_in);
		boot <= 8'h6e;
		br(16'h0123, 1'b1);
		`CHK(got, 8'h6e)
		`CHK(baddr, 16'h0123)
		bus(16'h0000, 8'h77, 8'h05);
		`CHK(page, 8'h11)
	endtask : t_boot
	task automatic conclude;
		if (num_errors == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : conclude
	// Main sequence; a second reset at the end must clear the config
	initial begin
		t_reset();
		t_page();
		t_port1();
		t_port2();
		t_spec();
		t_irq();
		t_boot();
		t_reset();
		conclude();
	end
	// Whole run needs under two thousand cycles
	initial begin
		repeat (20000) @(posedge clk_in);
		num_errors++;
		conclude();
	end
endmodule : tb_dsp_memory_port_pin_functions
